/* logic/dmb_pkg.sv */
// Package: offsets, field layout, reset values and timing for the driver monitor/bias bank
package dmb_pkg;
  // Register offsets in the device map
  localparam logic [8:0] DMB_BATT_OFS  = 9'h184;
  localparam logic [8:0] DMB_THR12_OFS = 9'h185;
  localparam logic [8:0] DMB_THR34_OFS = 9'h186;
  localparam logic [8:0] DMB_THR5_OFS  = 9'h187;
  localparam logic [8:0] DMB_NEG5_OFS  = 9'h188;
  localparam logic [8:0] DMB_THR6_OFS  = 9'h189;
  localparam logic [8:0] DMB_NEG6_OFS  = 9'h18a;
  localparam logic [8:0] DMB_HS_OFS    = 9'h18b;
  localparam logic [8:0] DMB_LS_OFS    = 9'h18c;
  // Field widths and counts
  localparam int DMB_AW     = 9;
  localparam int DMB_DW     = 16;
  localparam int DMB_THR_W  = 8;
  localparam int DMB_NEG_W  = 5;
  localparam int DMB_BATT_W = 6;
  localparam int DMB_HS_N   = 7;
  localparam int DMB_LS_N   = 8;
  localparam int DMB_UC_N   = 6;
  localparam int DMB_PRE_W  = 4;
  // Field positions
  localparam int DMB_THR_HI_POS = 8;
  localparam int DMB_SPU2_POS   = 9;
  localparam int DMB_SPU4_POS   = 11;
  // Reset values
  localparam logic [7:0] DMB_THR_RST  = 8'h00;
  localparam logic [4:0] DMB_NEG_RST  = 5'h00;
  localparam logic [5:0] DMB_BATT_RST = 6'h00;
  localparam logic [6:0] DMB_HS_RST   = 7'h00;
  localparam logic [1:0] DMB_SPU_RST  = 2'h0;
  localparam logic [7:0] DMB_LS_RST   = 8'hff;
  // Successive-step conversion: first trial code and steps per conversion
  localparam logic [5:0] DMB_SAR_START = 6'h20;
  localparam logic [2:0] DMB_CONV_LAST = 3'h6;  // Steps 0..6, seven steps in all
  localparam logic [2:0] DMB_MSB_IDX   = 3'h5;
endpackage

/* logic/dmb_bank.sv */
// Driver monitor and bias register bank: battery conversion, thresholds, bias enables
// Summary of operation
// RULE_01: Battery result readable by serial host and microcores
// RULE_02: Conversion runs continuously, seven steps per result
// RULE_03: Prescaler setting sets each conversion step length
// RULE_04: Serial host may write channel threshold registers
// RULE_05: Microcore bias writes need output access right
// RULE_06: High-sides two and four add strong pull-up
// RULE_07: Bias readback shows applied, masked configuration
// RULE_08: Low-side pull-downs reset on; writes can turn them off unless bs_ls_force holds them on
// RULE_09: Writes to read-only or reserved bits ignored
`timescale 1ns/1ns
module dmb_bank
  import dmb_pkg::*;
(
  input  wire logic                                       clk,
  input  wire logic                                       rstn,
  input  wire logic                                       spi_wr,
  input  wire logic                                       spi_rd,
  input  wire logic [dmb_pkg::DMB_AW-1:0]                 spi_addr,
  input  wire logic [dmb_pkg::DMB_DW-1:0]                 spi_wdata,
  output logic      [dmb_pkg::DMB_DW-1:0]                 spi_rdata,
  input  wire logic                                       uc_wr,
  input  wire logic                                       uc_rd,
  input  wire logic [2:0]                                 uc_id,
  input  wire logic [dmb_pkg::DMB_AW-1:0]                 uc_addr,
  input  wire logic [dmb_pkg::DMB_DW-1:0]                 uc_wdata,
  output logic      [dmb_pkg::DMB_DW-1:0]                 uc_rdata,
  input  wire logic [dmb_pkg::DMB_UC_N-1:0][dmb_pkg::DMB_HS_N-1:0] uc_hs_access,
  input  wire logic [dmb_pkg::DMB_UC_N-1:0][dmb_pkg::DMB_LS_N-1:0] uc_ls_access,
  input  wire logic [dmb_pkg::DMB_PRE_W-1:0]              ofs_comp_prescaler,
  input  wire logic                                       batt_cmp,
  output logic      [dmb_pkg::DMB_BATT_W-1:0]             batt_dac_code,
  input  wire logic [dmb_pkg::DMB_HS_N-1:0]               bs_hs_mask,
  input  wire logic [dmb_pkg::DMB_LS_N-1:0]               bs_ls_force,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch1,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch2,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch3,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch4,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch5_low,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch5_high,
  output logic      [dmb_pkg::DMB_NEG_W-1:0]              current_threshold_ch5_negative,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch6_low,
  output logic      [dmb_pkg::DMB_THR_W-1:0]              current_threshold_ch6_high,
  output logic      [dmb_pkg::DMB_NEG_W-1:0]              current_threshold_ch6_negative,
  output logic      [dmb_pkg::DMB_HS_N-1:0]               highside_pullup_enable,
  output logic      [1:0]                                 highside_strong_pullup_enable,
  output logic      [dmb_pkg::DMB_LS_N-1:0]               lowside_pulldown_enable
);
  import dmb_pkg::*;

  // Comparator synchroniser, first stage read only by the second
  logic                 cmp_s1_reg;
  logic                 cmp_s2_reg;
  // Conversion state
  logic [2:0]           step_reg,    step_next;     // Step within a conversion
  logic [DMB_PRE_W-1:0] pre_reg,     pre_next;      // Clocks within a step
  logic [5:0]           sar_reg,     sar_next;      // Trial code driven to the converter
  logic [5:0]           batt_reg,    batt_next;     // Posted result
  // Stored configuration
  logic [15:0]          thr12_reg,   thr12_next;
  logic [15:0]          thr34_reg,   thr34_next;
  logic [15:0]          thr5_reg,    thr5_next;
  logic [4:0]           neg5_reg,    neg5_next;
  logic [15:0]          thr6_reg,    thr6_next;
  logic [4:0]           neg6_reg,    neg6_next;
  logic [6:0]           hs_reg,      hs_next;       // Standard pull-up enables
  logic [1:0]           spu_reg,     spu_next;      // Strong pull-up, outputs 2 and 4
  logic [7:0]           ls_reg,      ls_next;       // Pull-down enables
  // Applied bias after the bootstrap masks
  logic [6:0]           hs_app_reg,  hs_app_next;
  logic [1:0]           spu_app_reg, spu_app_next;
  logic [7:0]           ls_app_reg,  ls_app_next;
  // Read data holding registers
  logic [15:0]          spi_rd_reg,  spi_rd_next;
  logic [15:0]          uc_rd_reg,   uc_rd_next;
  // Decoded helpers
  logic                 step_end;                   // Last clock of a step
  logic                 uc_ok;                      // Microcore id is in range
  logic [6:0]           uc_hs_acc;                  // Caller's high-side rights
  logic [7:0]           uc_ls_acc;                  // Caller's low-side rights
  logic [2:0]           bit_idx;

  // Merge only the bits that the caller may change
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] allow);
    merge = (old_v & ~allow) | (new_v & allow);
  endfunction

  // Register read map; bias reads show the applied bias, reserved bits read zero
  function automatic logic [15:0] reg_read(input logic [DMB_AW-1:0] a);
    reg_read = 16'h0000;
    unique case (a)
      DMB_BATT_OFS:  reg_read = {10'h000, batt_reg};   // RULE_01
      DMB_THR12_OFS: reg_read = thr12_reg;
      DMB_THR34_OFS: reg_read = thr34_reg;
      DMB_THR5_OFS:  reg_read = thr5_reg;
      DMB_NEG5_OFS:  reg_read = {11'h000, neg5_reg};
      DMB_THR6_OFS:  reg_read = thr6_reg;
      DMB_NEG6_OFS:  reg_read = {11'h000, neg6_reg};
      DMB_HS_OFS:    reg_read = {4'h0, spu_app_reg[1], 1'b0, spu_app_reg[0], 2'h0,
                                 hs_app_reg};          // RULE_07
      DMB_LS_OFS:    reg_read = {8'h00, ls_app_reg};   // RULE_07
      default:       reg_read = 16'h0000;              // Unmapped reads zero
    endcase
  endfunction

  // Comparator arrives from the analog side, so it is synchronised first
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      cmp_s1_reg <= batt_cmp;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // Successive-step conversion, free running; no start command exists
  always_comb begin
    step_end  = (pre_reg == ofs_comp_prescaler);       // RULE_03
    bit_idx   = DMB_MSB_IDX - step_reg;
    step_next = step_reg;
    pre_next  = step_end ? '0 : pre_reg + 1'b1;        // RULE_03
    sar_next  = sar_reg;
    batt_next = batt_reg;
    if (step_end) begin
      if (step_reg == DMB_CONV_LAST) begin
        // Seventh step posts the result and restarts
        batt_next = sar_reg;                           // RULE_02
        sar_next  = DMB_SAR_START;
        step_next = '0;
      end else begin
        // Keep the trial bit while the battery is above the trial level
        sar_next[bit_idx] = cmp_s2_reg;
        if (bit_idx != 3'h0) begin
          sar_next[bit_idx - 3'h1] = 1'b1;
        end
        step_next = step_reg + 3'h1;                   // RULE_02
      end
    end
  end

  // Conversion registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      step_reg <= '0;
      pre_reg  <= '0;
      sar_reg  <= DMB_SAR_START;
      batt_reg <= DMB_BATT_RST;
    end else begin
      step_reg <= step_next;
      pre_reg  <= pre_next;
      sar_reg  <= sar_next;
      batt_reg <= batt_next;
    end
  end

  // Write decode; a serial write lands after a microcore write to the same place
  always_comb begin
    uc_ok      = (uc_id < 3'(DMB_UC_N));
    uc_hs_acc  = uc_ok ? uc_hs_access[uc_id] : '0;
    uc_ls_acc  = uc_ok ? uc_ls_access[uc_id] : '0;
    thr12_next = thr12_reg;
    thr34_next = thr34_reg;
    thr5_next  = thr5_reg;
    neg5_next  = neg5_reg;
    thr6_next  = thr6_reg;
    neg6_next  = neg6_reg;
    hs_next    = hs_reg;
    spu_next   = spu_reg;
    ls_next    = ls_reg;
    // Microcores: thresholds freely, bias only where rights are held
    if (uc_wr) begin
      unique case (uc_addr)
        DMB_THR12_OFS: thr12_next = uc_wdata;
        DMB_THR34_OFS: thr34_next = uc_wdata;
        DMB_THR5_OFS:  thr5_next  = uc_wdata;
        DMB_NEG5_OFS:  neg5_next  = uc_wdata[DMB_NEG_W-1:0];
        DMB_THR6_OFS:  thr6_next  = uc_wdata;
        DMB_NEG6_OFS:  neg6_next  = uc_wdata[DMB_NEG_W-1:0];
        DMB_HS_OFS: begin
          hs_next = 7'(merge({1'b0, hs_reg}, {1'b0, uc_wdata[6:0]},
                             {1'b0, uc_hs_acc}));      // RULE_05
          if (uc_hs_acc[1]) begin
            spu_next[0] = uc_wdata[DMB_SPU2_POS];      // RULE_05
          end
          if (uc_hs_acc[3]) begin
            spu_next[1] = uc_wdata[DMB_SPU4_POS];      // RULE_05
          end
        end
        DMB_LS_OFS:    ls_next = merge(ls_reg, uc_wdata[7:0], uc_ls_acc); // RULE_05
        default: begin
          // Result register and unmapped offsets take no write
        end
      endcase
    end
    // Serial host: full access to every writable field
    if (spi_wr) begin
      unique case (spi_addr)
        DMB_THR12_OFS: thr12_next = spi_wdata;                  // RULE_04
        DMB_THR34_OFS: thr34_next = spi_wdata;                  // RULE_04
        DMB_THR5_OFS:  thr5_next  = spi_wdata;                  // RULE_04
        DMB_NEG5_OFS:  neg5_next  = spi_wdata[DMB_NEG_W-1:0];   // RULE_09
        DMB_THR6_OFS:  thr6_next  = spi_wdata;                  // RULE_04
        DMB_NEG6_OFS:  neg6_next  = spi_wdata[DMB_NEG_W-1:0];   // RULE_09
        DMB_HS_OFS: begin
          hs_next  = spi_wdata[6:0];
          spu_next = {spi_wdata[DMB_SPU4_POS], spi_wdata[DMB_SPU2_POS]}; // RULE_06
        end
        DMB_LS_OFS:    ls_next = spi_wdata[7:0];
        default: begin
          // Battery result is read-only; writes are dropped
        end
      endcase
    end
  end

  // Applied bias: init masks cut high-side pull-ups, never low-side pull-downs
  always_comb begin
    hs_app_next  = hs_reg & ~bs_hs_mask;
    spu_app_next = spu_reg & ~{bs_hs_mask[3], bs_hs_mask[1]};   // RULE_06
    ls_app_next  = ls_reg | bs_ls_force;                        // RULE_08
    spi_rd_next  = spi_rd ? reg_read(spi_addr) : spi_rd_reg;
    uc_rd_next   = uc_rd ? reg_read(uc_addr) : uc_rd_reg;       // RULE_01
  end

  // Configuration, applied bias and read data registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      thr12_reg   <= {DMB_THR_RST, DMB_THR_RST};
      thr34_reg   <= {DMB_THR_RST, DMB_THR_RST};
      thr5_reg    <= {DMB_THR_RST, DMB_THR_RST};
      neg5_reg    <= DMB_NEG_RST;
      thr6_reg    <= {DMB_THR_RST, DMB_THR_RST};
      neg6_reg    <= DMB_NEG_RST;
      hs_reg      <= DMB_HS_RST;
      spu_reg     <= DMB_SPU_RST;
      ls_reg      <= DMB_LS_RST;                                // RULE_08
      hs_app_reg  <= DMB_HS_RST;
      spu_app_reg <= DMB_SPU_RST;
      ls_app_reg  <= DMB_LS_RST;                                // RULE_08
      spi_rd_reg  <= 16'h0000;
      uc_rd_reg   <= 16'h0000;
    end else begin
      thr12_reg   <= thr12_next;
      thr34_reg   <= thr34_next;
      thr5_reg    <= thr5_next;
      neg5_reg    <= neg5_next;
      thr6_reg    <= thr6_next;
      neg6_reg    <= neg6_next;
      hs_reg      <= hs_next;
      spu_reg     <= spu_next;
      ls_reg      <= ls_next;
      hs_app_reg  <= hs_app_next;
      spu_app_reg <= spu_app_next;
      ls_app_reg  <= ls_app_next;
      spi_rd_reg  <= spi_rd_next;
      uc_rd_reg   <= uc_rd_next;
    end
  end

  // Outputs, all from flip-flops
  assign spi_rdata                      = spi_rd_reg;
  assign uc_rdata                       = uc_rd_reg;
  assign batt_dac_code                  = sar_reg;
  assign current_threshold_ch1          = thr12_reg[DMB_THR_W-1:0];
  assign current_threshold_ch2          = thr12_reg[DMB_THR_HI_POS +: DMB_THR_W];
  assign current_threshold_ch3          = thr34_reg[DMB_THR_W-1:0];
  assign current_threshold_ch4          = thr34_reg[DMB_THR_HI_POS +: DMB_THR_W];
  assign current_threshold_ch5_low      = thr5_reg[DMB_THR_W-1:0];
  assign current_threshold_ch5_high     = thr5_reg[DMB_THR_HI_POS +: DMB_THR_W];
  assign current_threshold_ch5_negative = neg5_reg;
  assign current_threshold_ch6_low      = thr6_reg[DMB_THR_W-1:0];
  assign current_threshold_ch6_high     = thr6_reg[DMB_THR_HI_POS +: DMB_THR_W];
  assign current_threshold_ch6_negative = neg6_reg;
  assign highside_pullup_enable         = hs_app_reg;
  assign highside_strong_pullup_enable  = spu_app_reg;
  assign lowside_pulldown_enable        = ls_app_reg;

  // Checks
  default clocking dmb_cb @(posedge clk); endclocking
  default disable iff (!rstn);

  batt_post_a: assert property (step_end && step_reg == DMB_CONV_LAST |=> // RULE_02
    batt_reg == $past(sar_reg) && sar_reg == DMB_SAR_START && step_reg == 3'h0)
    else $error("result not posted at end of conversion");
  step_range_a: assert property (step_reg <= DMB_CONV_LAST) // RULE_02
    else $error("conversion step out of range");
  step_hold_a: assert property (!step_end |=> $stable(sar_reg) && $stable(step_reg)) // RULE_03
    else $error("step advanced before prescaler count");
  batt_read_a: assert property (spi_rd && spi_addr == DMB_BATT_OFS |=> // RULE_01
    spi_rdata == {10'h000, $past(batt_reg)})
    else $error("serial battery read wrong");
  uc_batt_read_a: assert property (uc_rd && uc_addr == DMB_BATT_OFS |=> // RULE_01
    uc_rdata == {10'h000, $past(batt_reg)})
    else $error("microcore battery read wrong");
  ro_write_a: assert property (spi_wr && spi_addr == DMB_BATT_OFS && !step_end |=> // RULE_09
    $stable(batt_reg))
    else $error("write disturbed battery result");
  thr_write_a: assert property (spi_wr && spi_addr == DMB_THR12_OFS |=> // RULE_04
    current_threshold_ch2 == $past(spi_wdata[15:8]) &&
    current_threshold_ch1 == $past(spi_wdata[7:0]))
    else $error("threshold write lost");
  uc_rights_a: assert property (uc_wr && !spi_wr && uc_addr == DMB_HS_OFS && // RULE_05
    uc_hs_acc == 7'h00 |=> $stable(hs_reg) && $stable(spu_reg))
    else $error("microcore changed bias without rights");
  spu_write_a: assert property (spi_wr && spi_addr == DMB_HS_OFS |=> // RULE_06
    spu_reg == {$past(spi_wdata[DMB_SPU4_POS]), $past(spi_wdata[DMB_SPU2_POS])})
    else $error("strong pull-up write lost");
  hs_readback_a: assert property (spi_rd && spi_addr == DMB_HS_OFS |=> // RULE_07
    spi_rdata[6:0] == $past(hs_app_reg))
    else $error("bias readback not applied value");
  ls_reset_a: assert property (!$past(rstn) |-> ls_reg == 8'hff) // RULE_08
    else $error("pull-downs not on after reset");
endmodule // dmb_bank

/* bench/dmb_batt_model.sv */
// Battery front end model: comparator of a set battery level against the trial code
`timescale 1ns/1ns
module dmb_batt_model (
  input  wire logic       clk,
  input  wire logic [5:0] level,
  input  wire logic [5:0] trial_code,
  output logic            above
);
  // High while the battery sits at or above the trial code; the design resynchronises it.
  // The model answers at once, which is the fastest case the converter must handle.
  assign above = (level >= trial_code);
endmodule // dmb_batt_model

/* bench/driver_monitor_bias_regs_tb.sv */
// Self-checking bench for the driver monitor and bias register bank
`timescale 1ns/1ns
module driver_monitor_bias_regs_tb;
  import dmb_pkg::*;
  logic              clk, rstn, spi_wr, spi_rd, uc_wr, uc_rd, batt_cmp;
  logic [8:0]        spi_addr, uc_addr;
  logic [15:0]       spi_wdata, uc_wdata, spi_rdata, uc_rdata, q, d, alw;
  logic [2:0]        uc_id;
  logic [5:0][6:0]   uc_hs_access;
  logic [5:0][7:0]   uc_ls_access;
  logic [3:0]        ofs_comp_prescaler;
  logic [5:0]        batt_dac_code, level;
  logic [6:0]        bs_hs_mask, highside_pullup_enable;
  logic [7:0]        bs_ls_force, lowside_pulldown_enable;
  logic [1:0]        highside_strong_pullup_enable;
  logic [7:0]        current_threshold_ch1, current_threshold_ch2, current_threshold_ch3;
  logic [7:0]        current_threshold_ch4, current_threshold_ch5_low, current_threshold_ch5_high;
  logic [7:0]        current_threshold_ch6_low, current_threshold_ch6_high;
  logic [4:0]        current_threshold_ch5_negative, current_threshold_ch6_negative;
  logic [15:0]       mdl [9'h185:9'h18c];  // Stored register model
  int                error_cnt, samples_checked, n;
  int                n4 [2] = '{3, 7};  // Prescaler settings for the conversion scenario

  dmb_bank uut (.clk, .rstn, .spi_wr, .spi_rd, .spi_addr, .spi_wdata, .spi_rdata, .uc_wr,
    .uc_rd, .uc_id, .uc_addr, .uc_wdata, .uc_rdata, .uc_hs_access, .uc_ls_access,
    .ofs_comp_prescaler, .batt_cmp, .batt_dac_code, .bs_hs_mask, .bs_ls_force,
    .current_threshold_ch1, .current_threshold_ch2, .current_threshold_ch3,
    .current_threshold_ch4, .current_threshold_ch5_low, .current_threshold_ch5_high,
    .current_threshold_ch5_negative, .current_threshold_ch6_low, .current_threshold_ch6_high,
    .current_threshold_ch6_negative, .highside_pullup_enable, .highside_strong_pullup_enable,
    .lowside_pulldown_enable);
  dmb_batt_model batt (.clk, .level, .trial_code(batt_dac_code), .above(batt_cmp));

  // Clock: 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Compare one value and count it
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Single closing point of the run
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One register access; strobe held one cycle, read data taken after the answer edge
  task automatic acc(input bit uc, input bit w, input logic [8:0] a, input logic [15:0] wd);
    @(posedge clk);
    if (uc) begin
      uc_wr <= w; uc_rd <= !w; uc_addr <= a; uc_wdata <= wd;
    end else begin
      spi_wr <= w; spi_rd <= !w; spi_addr <= a; spi_wdata <= wd;
    end
    @(posedge clk);
    spi_wr <= 1'b0; spi_rd <= 1'b0; uc_wr <= 1'b0; uc_rd <= 1'b0;
    #1 q = uc ? uc_rdata : spi_rdata;
  endtask

  // Writable bits per register; reserved positions drop out
  function automatic logic [15:0] keep(input logic [8:0] a);
    case (a)
      DMB_NEG5_OFS, DMB_NEG6_OFS: return 16'h001f;
      DMB_HS_OFS:                 return 16'h0a7f;
      DMB_LS_OFS:                 return 16'h00ff;
      default:                    return 16'hffff;
    endcase
  endfunction

  // Applied bias after the bootstrap masks, in register layout
  function automatic logic [15:0] hs_app();
    logic [15:0] s;
    s = mdl[DMB_HS_OFS];
    return {4'h0, s[11] & ~bs_hs_mask[3], 1'b0, s[9] & ~bs_hs_mask[1], 2'h0, s[6:0] & ~bs_hs_mask};
  endfunction
  function automatic logic [15:0] ls_app();
    return {8'h0, mdl[DMB_LS_OFS][7:0] | bs_ls_force};
  endfunction

  // Expected serial read: bias registers show the applied value, unmapped reads 0
  function automatic logic [15:0] exp_rd(input logic [8:0] a);
    if (a == DMB_BATT_OFS) return {10'h0, level};
    if (a == DMB_HS_OFS) return hs_app();
    if (a == DMB_LS_OFS) return ls_app();
    if (a > DMB_BATT_OFS && a < DMB_HS_OFS) return mdl[a];
    return 16'h0000;
  endfunction

  // Read every mapped offset plus one unmapped neighbour
  task automatic rd_all();
    for (int a = 9'h184; a <= 9'h18d; a++) begin
      acc(1'b0, 1'b0, 9'(a), 16'h0000);
      check("spi_rdata", q, exp_rd(9'(a)));
    end
  endtask

  // Compare every threshold and bias output with the model
  task automatic check_outs();
    check("thr12", {current_threshold_ch2, current_threshold_ch1}, mdl[DMB_THR12_OFS]);
    check("thr34", {current_threshold_ch4, current_threshold_ch3}, mdl[DMB_THR34_OFS]);
    check("thr5", {current_threshold_ch5_high, current_threshold_ch5_low},
      mdl[DMB_THR5_OFS]);
    check("neg5", {11'h0, current_threshold_ch5_negative}, mdl[DMB_NEG5_OFS]);
    check("thr6", {current_threshold_ch6_high, current_threshold_ch6_low},
      mdl[DMB_THR6_OFS]);
    check("neg6", {11'h0, current_threshold_ch6_negative}, mdl[DMB_NEG6_OFS]);
    check("hs_out", {4'h0, highside_strong_pullup_enable[1], 1'b0,
      highside_strong_pullup_enable[0], 2'h0, highside_pullup_enable}, hs_app());
    check("ls_out", {8'h0, lowside_pulldown_enable}, ls_app());
  endtask

  // Wait, bounded, until the trial code is (or is not) the start code
  task automatic till(input bit eq);
    for (int i = 0; i < 300 && ((batt_dac_code === 6'h20) != eq); i++) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Watchdog: the full sequence needs well under this span
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    rstn = 1'b0; spi_wr = 1'b0; spi_rd = 1'b0; uc_wr = 1'b0; uc_rd = 1'b0;
    spi_addr = 9'h000; uc_addr = 9'h000; spi_wdata = 16'h0000; uc_wdata = 16'h0000;
    uc_id = 3'h0; uc_hs_access = '0; uc_ls_access = '0; ofs_comp_prescaler = 4'h3;
    level = 6'h15; bs_hs_mask = 7'h00; bs_ls_force = 8'h00;
    error_cnt = 0; samples_checked = 0;
    void'($urandom(32'hb4010b1c));
    for (int a = 9'h185; a <= 9'h18c; a++) mdl[a] = (a == 9'h18c) ? 16'h00ff : 16'h0000;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check_outs();
    // Continuous conversion at two step lengths; odd levels never match the start code
    foreach (n4[k]) begin
      @(posedge clk);
      ofs_comp_prescaler <= 4'(n4[k]);
      level <= 6'($urandom) | 6'h01;
      repeat (25 * (n4[k] + 1)) @(posedge clk);
      till(1'b0);
      till(1'b1);
      n = 0;
      while (batt_dac_code === 6'h20 && n < 300) begin @(posedge clk); #1; n++; end
      check("step_len", 16'(n), 16'(n4[k] + 1));
      while (batt_dac_code !== 6'h20 && n < 300) begin @(posedge clk); #1; n++; end
      check("conv_len", 16'(n), 16'(7 * (n4[k] + 1)));
      acc(1'b0, 1'b1, DMB_BATT_OFS, 16'hffff);
      acc(1'b0, 1'b0, DMB_BATT_OFS, 16'h0000);
      check("batt_spi", q, {10'h0, level});
      uc_id <= 3'(k);
      acc(1'b1, 1'b0, DMB_BATT_OFS, 16'h0000);
      check("batt_uc", q, {10'h0, level});
    end
    // Serial threshold writes with random data, one idle cycle apart
    for (int a = 9'h185; a <= 9'h18a; a++) begin
      d = 16'($urandom);
      acc(1'b0, 1'b1, 9'(a), d);
      mdl[a] = d & keep(9'(a));
    end
    acc(1'b0, 1'b1, 9'h18d, 16'hffff); // Unmapped write changes nothing
    rd_all();
    check_outs();
    // Microcore threshold writes need no access right; read back on the microcore port
    for (int a = 9'h185; a <= 9'h18a; a++) begin
      d = 16'($urandom);
      acc(1'b1, 1'b1, 9'(a), d);
      mdl[a] = d & keep(9'(a));
      acc(1'b1, 1'b0, 9'(a), 16'h0000);
      check("uc_rdata", q, mdl[a]);
    end
    check_outs();
    // Serial bias writes under random bootstrap masks
    @(posedge clk);
    bs_hs_mask <= 7'($urandom);
    bs_ls_force <= 8'($urandom);
    acc(1'b0, 1'b1, DMB_HS_OFS, 16'hffff);
    mdl[DMB_HS_OFS] = 16'h0a7f;
    acc(1'b0, 1'b1, DMB_LS_OFS, 16'h0000);
    mdl[DMB_LS_OFS] = 16'h0000;
    repeat (3) @(posedge clk);
    #1;
    check_outs();
    rd_all();
    // Microcore bias writes: only bits whose output right is held may change
    for (int id = 0; id < 8; id++) begin
      @(posedge clk);
      uc_id <= 3'(id);
      uc_hs_access <= 42'({$urandom(), $urandom()});
      uc_ls_access <= 48'({$urandom(), $urandom()});
      @(posedge clk);
      #1;
      d = 16'($urandom);
      acc(1'b1, 1'b1, DMB_HS_OFS, d);
      alw = (id < 6) ? {4'h0, uc_hs_access[id][3], 1'b0, uc_hs_access[id][1], 2'h0,
        uc_hs_access[id]} : 16'h0000;
      mdl[DMB_HS_OFS] = (mdl[DMB_HS_OFS] & ~alw) | (d & alw);
      d = 16'($urandom);
      acc(1'b1, 1'b1, DMB_LS_OFS, d);
      alw = (id < 6) ? {8'h0, uc_ls_access[id]} : 16'h0000;
      mdl[DMB_LS_OFS] = (mdl[DMB_LS_OFS] & ~alw) | (d & alw);
      repeat (3) @(posedge clk);
      #1;
      check_outs();
    end
    rd_all();
    conclude();
  end

endmodule // driver_monitor_bias_regs_tb
